/* File: hw/cix_core.sv */
// core executing the instruction subset, axi4-lite control and status
//
// Decided for this implementation: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
// ****************************************************************
// Summary of operation
// - and-with-file ands accumulator, updates zero only
// - destination bit picks accumulator or file
// - skip-if-clear skips when bit is zero
// - skip-if-set skips when bit is one
// - skipped instruction becomes nop, two cycles
// - clear accumulator loads zero, sets zero flag
// - call pushes pc plus one
// - call loads pc low byte from literal
// - call pages pc from status, bit8 zero
// - call takes two cycles, flags unchanged
// - clear watchdog zeroes the watchdog counter
// - prescaler cleared only when assigned to watchdog
// - clear watchdog sets expiry and sleep flags
// - bit tests decoded from 0110/0111 patterns
// - clear watchdog is word 004, one cycle
// ****************************************************************
module cix_core
  import cix_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  output logic [PC_W-1:0] pmem_addr,
  input wire logic [IW_W-1:0] pmem_data,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ****************************************************************
  // decode helpers
  // ****************************************************************
  function automatic logic is_bit_test(input logic [IW_W-1:0] iw);
    return (iw[11:8] == OP_BIT_CLR) || (iw[11:8] == OP_BIT_SET);
  endfunction

  function automatic logic [PC_W-1:0] pc_step(input logic [PC_W-1:0] pc);
    return PC_W'(pc + 1'b1);
  endfunction

  function automatic logic [7:0] set_bit(input logic [7:0] v, input int idx);
    logic [7:0] r;
    r = v;
    r[idx] = 1'b1;
    return r;
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  cix_state_t state_r, state_nxt;
  logic [PC_W-1:0] pc_r, pc_nxt;
  logic [IW_W-1:0] ir_r, ir_nxt;
  logic [7:0] acc_r, acc_nxt;
  logic [7:0] status_r, status_nxt;
  logic [7:0] dog_r, dog_nxt;
  logic [7:0] pre_r, pre_nxt;
  logic [PC_W-1:0] stack_r, stack_nxt;
  logic run_r, run_nxt;
  logic pre_to_dog_r, pre_to_dog_nxt;
  logic [7:0] fdata;
  logic fwe;
  logic [7:0] fwdata;
  logic [7:0] and_res;
  logic bit_val;

  // axi state
  logic awready_r, awready_nxt;
  logic wready_r, wready_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic arready_r, arready_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic aw_have_r, aw_have_nxt;
  logic w_have_r, w_have_nxt;
  logic [31:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic wr_fire;

  // the read address is taken straight from the fetched word, so the
  // registered memory output is valid exactly in the execute cycle
  cix_file_mem u_mem (
    .aclk(aclk),
    .raddr(pmem_data[4:0]),
    .rdata(fdata),
    .we(fwe),
    .waddr(ir_r[4:0]),
    .wdata(fwdata)
  );

  // ****************************************************************
  // execution
  // ****************************************************************
  always_comb begin
    state_nxt = state_r;
    pc_nxt = pc_r;
    ir_nxt = ir_r;
    acc_nxt = acc_r;
    status_nxt = status_r;
    // free-running counters; a clear below wins even when the count is zero
    dog_nxt = 8'(dog_r + 1'b1);
    pre_nxt = 8'(pre_r + 1'b1);
    stack_nxt = stack_r;
    fwe = 1'b0;
    fwdata = 8'h00;
    and_res = acc_r & fdata;
    bit_val = fdata[ir_r[7:5]];
    unique case (state_r)
      ST_HALT: begin
        if (run_r) begin
          state_nxt = ST_FETCH;
        end
      end
      ST_FETCH: begin
        ir_nxt = pmem_data;
        pc_nxt = pc_step(pc_r);
        state_nxt = ST_EXEC;
      end
      ST_EXEC: begin
        state_nxt = run_r ? ST_FETCH : ST_HALT;
        if (ir_r[11:6] == OP_AND_FILE) begin
          status_nxt[STAT_Z] = (and_res == 8'h00);
          if (ir_r[5]) begin
            fwe = 1'b1;
            fwdata = and_res;
          end else begin
            acc_nxt = and_res;
          end
        end else if (is_bit_test(ir_r)) begin
          if ((ir_r[8] == 1'b0 && !bit_val) || (ir_r[8] == 1'b1 && bit_val)) begin
            // step over the next word; the flush cycle is the nop in its place
            pc_nxt = pc_step(pc_r);
            state_nxt = ST_FLUSH;
          end
        end else if (ir_r == OP_CLR_ACC) begin
          acc_nxt = 8'h00;
          status_nxt[STAT_Z] = 1'b1;
        end else if (ir_r[11:8] == OP_CALL) begin
          stack_nxt = pc_r;
          pc_nxt = {status_r[STAT_PAGE_LO+1:STAT_PAGE_LO], 1'b0, ir_r[7:0]};
          state_nxt = ST_FLUSH;
        end else if (ir_r == OP_CLR_DOG) begin
          dog_nxt = 8'h00;
          if (pre_to_dog_r) begin
            pre_nxt = 8'h00;
          end
          status_nxt = set_bit(set_bit(status_r, STAT_EXPIRY), STAT_SLEEP);
        end
      end
      ST_FLUSH: begin
        // second cycle: fetched word discarded, nothing else touched
        state_nxt = run_r ? ST_FETCH : ST_HALT;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= ST_HALT;
      pc_r <= PC_RST;
      ir_r <= OP_NOP;
      acc_r <= ACC_RST;
      status_r <= STATUS_RST;
      dog_r <= DOG_RST;
      pre_r <= PRE_RST;
      stack_r <= PC_RST;
    end else begin
      state_r <= state_nxt;
      pc_r <= pc_nxt;
      ir_r <= ir_nxt;
      acc_r <= acc_nxt;
      status_r <= status_nxt;
      dog_r <= dog_nxt;
      pre_r <= pre_nxt;
      stack_r <= stack_nxt;
    end
  end

  // ****************************************************************
  // axi4-lite slave
  // ****************************************************************
  always_comb begin
    awready_nxt = 1'b0;
    wready_nxt = 1'b0;
    arready_nxt = 1'b0;
    aw_have_nxt = aw_have_r;
    w_have_nxt = w_have_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    run_nxt = run_r;
    pre_to_dog_nxt = pre_to_dog_r;
    wr_fire = 1'b0;
    if (s_axi_awvalid && awready_r) begin
      aw_have_nxt = 1'b1;
      awaddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_r) begin
      w_have_nxt = 1'b1;
      wdata_nxt = s_axi_wdata;
    end
    if (!aw_have_r && !awready_r && !bvalid_r) begin
      awready_nxt = s_axi_awvalid;
    end
    if (!w_have_r && !wready_r && !bvalid_r) begin
      wready_nxt = s_axi_wvalid;
    end
    if (aw_have_r && w_have_r && !bvalid_r) begin
      wr_fire = 1'b1;
      aw_have_nxt = 1'b0;
      w_have_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = RESP_OKAY;
      if (awaddr_r == ADDR_CTRL) begin
        run_nxt = wdata_r[0];
        pre_to_dog_nxt = wdata_r[1];
      end else begin
        // other registers are read-only; strobes ignored as the only writable register holds two bits
        bresp_nxt = RESP_SLVERR;
      end
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (!rvalid_r && !arready_r) begin
      arready_nxt = s_axi_arvalid;
    end
    if (s_axi_arvalid && arready_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = RESP_OKAY;
      unique case (s_axi_araddr)
        ADDR_CTRL: rdata_nxt = {30'h0, pre_to_dog_r, run_r};
        ADDR_ACC: rdata_nxt = {24'h0, acc_r};
        ADDR_STATUS: rdata_nxt = {24'h0, status_r};
        ADDR_PC: rdata_nxt = {21'h0, pc_r};
        ADDR_DOG: rdata_nxt = {16'h0, pre_r, dog_r};
        ADDR_STACK: rdata_nxt = {21'h0, stack_r};
        default: begin
          rdata_nxt = 32'h0;
          rresp_nxt = RESP_SLVERR;
        end
      endcase
    end
    if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      arready_r <= 1'b0;
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awaddr_r <= 32'h0;
      wdata_r <= 32'h0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      rvalid_r <= 1'b0;
      rresp_r <= RESP_OKAY;
      rdata_r <= 32'h0;
      run_r <= 1'b0;
      pre_to_dog_r <= 1'b0;
    end else begin
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      arready_r <= arready_nxt;
      aw_have_r <= aw_have_nxt;
      w_have_r <= w_have_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
      run_r <= run_nxt;
      pre_to_dog_r <= pre_to_dog_nxt;
    end
  end

  assign pmem_addr = pc_r;
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;
endmodule

/* File: shared/cix_pkg.sv */
// package: constants and types for the instruction execution subset core
package cix_pkg;
  localparam int PC_W = 11;
  localparam int IW_W = 12;
  localparam int FILE_DEPTH = 32;
  localparam logic [3:0] OP_BIT_CLR = 4'h6;
  localparam logic [3:0] OP_BIT_SET = 4'h7;
  localparam logic [3:0] OP_CALL = 4'h9;
  localparam logic [5:0] OP_AND_FILE = 6'h05;
  localparam logic [11:0] OP_CLR_ACC = 12'h040;
  localparam logic [11:0] OP_CLR_DOG = 12'h004;
  localparam logic [11:0] OP_NOP = 12'h000;
  localparam int STAT_Z = 2;
  localparam int STAT_SLEEP = 3;
  localparam int STAT_EXPIRY = 4;
  localparam int STAT_PAGE_LO = 5;
  localparam logic [4:0] STATUS_ADDR = 5'h03;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] STATUS_RST = 8'h18;
  localparam logic [PC_W-1:0] PC_RST = 11'h000;
  localparam logic [7:0] DOG_RST = 8'h00;
  localparam logic [7:0] PRE_RST = 8'h00;
  localparam logic [31:0] ADDR_CTRL = 32'h0000_0000;
  localparam logic [31:0] ADDR_ACC = 32'h0000_0004;
  localparam logic [31:0] ADDR_STATUS = 32'h0000_0008;
  localparam logic [31:0] ADDR_PC = 32'h0000_000c;
  localparam logic [31:0] ADDR_DOG = 32'h0000_0010;
  localparam logic [31:0] ADDR_STACK = 32'h0000_0014;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [3:0] {
    ST_FETCH = 4'b0001,
    ST_EXEC = 4'b0010,
    ST_FLUSH = 4'b0100,
    ST_HALT = 4'b1000
  } cix_state_t;
endpackage

/* File: hw/cix_file_mem.sv */
// file register memory, 32 bytes, registered read port
`timescale 1ns/1ps
module cix_file_mem
  import cix_pkg::*;
(
  input wire logic aclk,
  input wire logic [4:0] raddr,
  output logic [7:0] rdata,
  input wire logic we,
  input wire logic [4:0] waddr,
  input wire logic [7:0] wdata
);
  logic [7:0] mem [FILE_DEPTH];
  logic [7:0] rdata_nxt;

  always_comb begin
    rdata_nxt = mem[raddr];
  end

  always_ff @(posedge aclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= rdata_nxt;
  end
endmodule

/* File: dv/cix_pmem_model.sv */
// program memory model: word store read without a clock
`timescale 1ns/1ps
module cix_pmem_model
  import cix_pkg::*;
(
  input wire logic [PC_W-1:0] pmem_addr,
  output logic [IW_W-1:0] pmem_data
);
  // ********
  // storage
  // ********
  logic [IW_W-1:0] mem [2**PC_W];
  // unloaded words are nops, so a stray fetch shows only in the pc
  initial begin
    for (int i = 0; i < 2**PC_W; i++) mem[i] = OP_NOP;
  end
  assign pmem_data = mem[pmem_addr];
endmodule

/* File: dv/cix_core_properties.sv */
// checker: bus handshake and program counter relations at the core pins
`timescale 1ns/1ps
module cix_core_properties
  import cix_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [PC_W-1:0] pmem_addr,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ********
  // properties
  // ********
  a_reset_pc_zero: assert property (disable iff (1'b0) !aresetn |=> pmem_addr == PC_RST)
    else $error("pc not cleared by reset");
  a_call_page_zero: assert property ($changed(pmem_addr) |->
    pmem_addr == $past(pmem_addr) + 11'h001 || pmem_addr[10:8] == 3'h0)
    else $error("pc jump off page");
  a_aw_one_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready too long");
  a_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
    else $error("read data dropped");
  a_r_after_ar: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  a_rd_unmapped: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > ADDR_STACK
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("bad unmapped read");
  a_wr_readonly: assert property (s_axi_awvalid && s_axi_awready && s_axi_awaddr != ADDR_CTRL
    |-> ##[1:3] s_axi_bvalid && s_axi_bresp == RESP_SLVERR) else $error("bad read-only write");
  c_write: cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == RESP_OKAY);
  c_refused: cover property (s_axi_rvalid && s_axi_rready && s_axi_rresp == RESP_SLVERR);
  c_jump: cover property ($changed(pmem_addr) && pmem_addr != $past(pmem_addr) + 11'h001);
endmodule
bind cix_core cix_core_properties u_cix_core_properties (
  .aclk(aclk),
  .aresetn(aresetn),
  .pmem_addr(pmem_addr),
  .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready),
  .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready)
);

/* File: dv/tb_cpu_instr_exec_subset.sv */
// testbench: runs a short program on the core and checks it over the bus
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin miscompares++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_cpu_instr_exec_subset
  import cix_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [PC_W-1:0] pmem_addr;
  logic [IW_W-1:0] pmem_data;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int miscompares = 0;
  int cmp_count = 0;
  int seed = 32'h69c43d48;
  cix_core u_cix_core (
    .aclk(aclk),
    .aresetn(aresetn),
    .pmem_addr(pmem_addr),
    .pmem_data(pmem_data),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready)
  );
  cix_pmem_model u_cix_pmem_model (
    .pmem_addr(pmem_addr),
    .pmem_data(pmem_data)
  );
  always #50 aclk = ~aclk;
  // ********
  // bus and program helpers
  // ********
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_left, w_left;
    aw_left = 1'b1;
    w_left = 1'b1;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (aw_left || w_left) begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) begin
        aw_left = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready === 1'b1) begin
        w_left = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    // a late bready makes the slave hold its response
    repeat ({$random(seed)} % 3) @(posedge aclk);
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    repeat ({$random(seed)} % 3) @(posedge aclk);
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic ld(input int a, input logic [IW_W-1:0] w);
    u_cix_pmem_model.mem[a] = w;
  endtask
  function automatic logic [PC_W-1:0] call_dest(input logic [7:0] k);
    return {STATUS_RST[6:5], 1'b0, k};
  endfunction
  // ********
  // one program run; m picks the prescaler owner
  // ********
  task automatic run_prog(input logic m);
    logic [7:0] k;
    logic [31:0] d;
    logic [1:0] r;
    k = 8'h30 + 8'({$random(seed)} % 208);
    @(posedge aclk);
    aresetn <= 1'b0;
    // file 5 is cleared first since file memory has no reset
    ld(0, {OP_AND_FILE, 1'b1, 5'h05});
    ld(1, {OP_BIT_CLR, 3'h3, 5'h05});
    ld(2, {OP_CALL, 8'h00});
    ld(3, {OP_BIT_SET, 3'h7, 5'h05});
    ld(4, OP_CLR_DOG);
    ld(5, OP_CLR_ACC);
    ld(6, {OP_CALL, 8'h20});
    ld(32, {OP_BIT_CLR, 3'({$random(seed)}), 5'h05});
    ld(33, {OP_CALL, 8'h00});
    ld(34, {OP_CALL, k});
    ld(k, {OP_CALL, k});
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    axi_wr(ADDR_CTRL, {30'h0, m, 1'b1}, r);
    `CHK(r, RESP_OKAY)
    d = 32'h0;
    for (int i = 0; i < 100 && d[10:0] !== call_dest(k); i++) axi_rd(ADDR_PC, d, r);
    axi_wr(ADDR_CTRL, {30'h0, m, 1'b0}, r);
    axi_wr(ADDR_ACC, 32'hff, r);
    `CHK(r, RESP_SLVERR)
    axi_rd(ADDR_CTRL, d, r);
    `CHK(d[1:0], {m, 1'b0})
    axi_rd(ADDR_ACC, d, r);
    `CHK(d[7:0], ACC_RST)
    axi_rd(ADDR_STATUS, d, r);
    `CHK(d[7:0], STATUS_RST | 8'(1 << STAT_Z))
    axi_rd(ADDR_PC, d, r);
    `CHK(d[10:0], call_dest(k))
    axi_rd(ADDR_STACK, d, r);
    `CHK(d[10:0], call_dest(k) + 11'h001)
    axi_rd(ADDR_DOG, d, r);
    `CHK(d[15:8] == d[7:0], m)
    axi_rd(32'h18 + 32'({$random(seed)} % 58) * 32'h4, d, r);
    `CHK(r, RESP_SLVERR)
    `CHK(d, 32'h0)
  endtask
  task tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    for (int m = 0; m < 2; m++) run_prog(m[0]);
    tally_and_finish;
  end
  initial begin
    #400000;
    miscompares++;
    tally_and_finish;
  end
endmodule
